//--- hdl/sbsc_control.sv
// Control logic of a synchronous burst SRAM with flow-through or pipelined reads
`include "sbsc_defs.svh"
module sbsc_control #(
    parameter int LANES = `SBSC_LANES_WIDE,
    parameter int LANE_BITS = `SBSC_LANE_BITS,
    parameter int ADDR_BITS = `SBSC_ADDR_BITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synchronous bus from the processor or cache controller
    input wire logic [ADDR_BITS-1:0] addr,
    input wire sbsc_pkg::sbsc_ctrl_type ctrl,
    input wire logic [LANES-1:0] lane_write_n,
    // Asynchronous output enable and mode pins
    input wire logic output_enable_n,
    input wire sbsc_pkg::sbsc_mode_type mode,
    // Data pins, split into input, output and per-lane enable
    input wire logic [LANES*LANE_BITS-1:0] dq_in,
    output logic [LANES*LANE_BITS-1:0] dq_out,
    output logic [LANES-1:0] dq_oe_n,
    // Storage array read port
    output logic mem_rd_en,
    output logic [ADDR_BITS-1:0] mem_rd_addr,
    input wire logic [LANES*LANE_BITS-1:0] mem_rdata,
    // Storage array write port
    output logic [LANES-1:0] mem_wr_lanes,
    output logic [ADDR_BITS-1:0] mem_wr_addr,
    output logic [LANES*LANE_BITS-1:0] mem_wdata,
    // Status
    output logic standby,
    output logic powered_down
);
    localparam int DATA_BITS = LANES * LANE_BITS;

    typedef struct packed {
        // Command captured at the last edge
        sbsc_pkg::sbsc_op_type cmd1;
        logic [ADDR_BITS-1:0] addr1;
        logic [LANES-1:0] lanes1;
        // Command one edge older, for the early turn-off
        sbsc_pkg::sbsc_op_type cmd2;
        // Array ports
        logic rd_en;
        logic [LANES-1:0] wr_lanes;
        logic [ADDR_BITS-1:0] wr_addr;
        logic [DATA_BITS-1:0] wdata;
        // Flow-through output stage
        logic flow_valid;
        logic [DATA_BITS-1:0] flow_data;
        // Pipelined output register
        logic pipe_valid;
        logic [DATA_BITS-1:0] pipe_data;
    } sbsc_state_type;

    sbsc_state_type state_reg;
    sbsc_state_type state_next;

    // Decoded command of this edge
    sbsc_pkg::sbsc_op_type op;
    logic chip_true;
    logic write_qual;
    logic [LANES-1:0] lane_mask;
    logic begin_burst;
    logic continue_burst;
    logic suspend_burst;
    logic [1:0] cur_low;
    logic [1:0] next_low;
    logic [ADDR_BITS-1:0] used_addr;
    logic [LANES-1:0] lane_n_present;
    logic drive;

    // Wide build has all four lanes; narrow build has a and b only
    generate
        if (LANES >= `SBSC_LANES_WIDE) begin : g_wide
            assign lane_n_present = lane_write_n;
        end else begin : g_narrow
            assign lane_n_present = lane_write_n[LANES-1:0];
        end
    endgenerate

    // Write qualifier and lane mask
    always_comb begin
        write_qual = ~ctrl.all_lanes_write_n
            | (~ctrl.byte_lane_gate_n & (|(~lane_n_present)));
        if (!ctrl.all_lanes_write_n) begin
            lane_mask = {LANES{1'b1}};
        end else if (!ctrl.byte_lane_gate_n) begin
            lane_mask = ~lane_n_present;
        end else begin
            lane_mask = '0;
        end
    end

    assign chip_true = ctrl.positive_select & ~ctrl.tertiary_select_n;

    // Command decode; sleep overrides everything so the array is untouched
    always_comb begin
        op = sbsc_pkg::OP_DESELECT;
        begin_burst = 1'b0;
        continue_burst = 1'b0;
        suspend_burst = 1'b0;
        if (mode.sleep_request) begin
            op = sbsc_pkg::OP_SLEEP;
        end else if (ctrl.primary_select_n && !ctrl.ctrl_load_strobe_n) begin
            op = sbsc_pkg::OP_DESELECT;
        end else if (!ctrl.primary_select_n && !chip_true
                     && (!ctrl.cpu_load_strobe_n || !ctrl.ctrl_load_strobe_n)) begin
            op = sbsc_pkg::OP_DESELECT;
        end else if (!ctrl.primary_select_n && !ctrl.cpu_load_strobe_n) begin
            // Processor strobe ignores the write inputs
            op = sbsc_pkg::OP_READ;
            begin_burst = 1'b1;
        end else if (!ctrl.primary_select_n && !ctrl.ctrl_load_strobe_n) begin
            op = write_qual ? sbsc_pkg::OP_WRITE : sbsc_pkg::OP_READ;
            begin_burst = 1'b1;
        end else begin
            // Both strobes high, or primary high with controller strobe high
            op = write_qual ? sbsc_pkg::OP_WRITE : sbsc_pkg::OP_READ;
            continue_burst = ~ctrl.burst_step_n;
            suspend_burst = ctrl.burst_step_n;
        end
    end

    // Counter steps on every continued access, even with outputs disabled
    sbsc_burst_counter u_counter (
        .clk(clk),
        .rst(rst),
        .load(begin_burst),
        .load_value(addr[`SBSC_LOW_LSB +: `SBSC_LOW_BITS]),
        .step(continue_burst),
        .interleave(mode.linear_order_select_n),
        .cur_low(cur_low),
        .next_low(next_low)
    );

    // Upper address bits come from the last loaded address
    always_comb begin
        used_addr = state_reg.addr1;
        if (begin_burst) begin
            used_addr = addr;
        end else if (continue_burst) begin
            used_addr[`SBSC_LOW_LSB +: `SBSC_LOW_BITS] = next_low;
        end else if (suspend_burst) begin
            used_addr[`SBSC_LOW_LSB +: `SBSC_LOW_BITS] = cur_low;
        end
    end

    // Pipeline of captured commands
    always_comb begin
        state_next = state_reg;
        state_next.cmd2 = state_reg.cmd1;
        state_next.cmd1 = op;
        state_next.lanes1 = '0;
        state_next.rd_en = 1'b0;
        state_next.wr_lanes = '0;
        if (begin_burst || continue_burst || suspend_burst) begin
            state_next.addr1 = used_addr;
        end
        case (op)
            sbsc_pkg::OP_READ: begin
                state_next.rd_en = 1'b1;
            end
            sbsc_pkg::OP_WRITE: begin
                state_next.lanes1 = lane_mask;
            end
            sbsc_pkg::OP_DESELECT: begin
                state_next.lanes1 = '0;
            end
            sbsc_pkg::OP_SLEEP: begin
                state_next.lanes1 = '0;
            end
            default: begin
                state_next.cmd1 = sbsc_pkg::OP_DESELECT;
            end
        endcase
        // Write data is taken one edge after its command
        if (state_reg.cmd1 == sbsc_pkg::OP_WRITE) begin
            state_next.wr_lanes = state_reg.lanes1;
            state_next.wr_addr = state_reg.addr1;
            state_next.wdata = dq_in;
        end
        // Flow-through stage catches the array word
        state_next.flow_valid = state_reg.rd_en;
        if (state_reg.rd_en) begin
            state_next.flow_data = mem_rdata;
        end
        // Pipelined mode adds one more register
        state_next.pipe_valid = state_reg.flow_valid;
        state_next.pipe_data = state_reg.flow_data;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '{
                cmd1: sbsc_pkg::OP_DESELECT,
                addr1: '0,
                lanes1: '0,
                cmd2: sbsc_pkg::OP_DESELECT,
                rd_en: 1'b0,
                wr_lanes: '0,
                wr_addr: '0,
                wdata: '0,
                flow_valid: 1'b0,
                flow_data: '0,
                pipe_valid: 1'b0,
                pipe_data: '0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    // Pin defaults: high flow select and low sleep mean pipelined, active
    always_comb begin
        if (!mode.flow_through_select_n) begin
            drive = state_reg.flow_valid;
            dq_out = state_reg.flow_data;
        end else begin
            // Single-cycle deselect: a newer non-read kills the older word
            drive = state_reg.pipe_valid
                & (state_reg.cmd2 == sbsc_pkg::OP_READ);
            dq_out = state_reg.pipe_data;
        end
    end

    // Output enable only gates; it never creates a drive on its own
    assign dq_oe_n = {LANES{~drive | output_enable_n}};

    assign mem_rd_en = state_reg.rd_en;
    assign mem_rd_addr = state_reg.addr1;
    assign mem_wr_lanes = state_reg.wr_lanes;
    assign mem_wr_addr = state_reg.wr_addr;
    assign mem_wdata = state_reg.wdata;
    assign standby = (state_reg.cmd1 == sbsc_pkg::OP_SLEEP);
    assign powered_down = (state_reg.cmd1 == sbsc_pkg::OP_DESELECT)
        | (state_reg.cmd1 == sbsc_pkg::OP_SLEEP);
endmodule : sbsc_control

//--- common/sbsc_defs.svh
// Constants of the synchronous burst SRAM control block
// Summary of operation
// - Burst order pin picks linear or XOR order
// - Two low address bits preset the counter
// - Counter wraps to loaded value on fifth clock
// - Both strobes high, step low: next address
// - Three deselect cases power down, outputs off
// - Read burst begins on two strobe cases
// - Write burst needs controller strobe and qualifier
// - Primary high, controller strobe high: continue or suspend
// - Step high holds address, repeats the access
// - Global write low writes every lane
// - Gate low writes exactly the low lanes
// - Reads drive every lane
// - Writes keep every lane at high impedance
// - Lanes c and d only in wide build
// - Output enable high turns drivers off at once
// - Output enable low only permits read drivers
// - Flow select low bypasses the output register
// - Sleep input high means standby
// - Open mode pins give pipelined, active operation
// - Pipelined reads add one output register stage
// - Deselect turns pipelined outputs off one stage early
// - Reads with outputs disabled still step counter
// - Memory contents kept during sleep
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH
`define SBSC_LANE_BITS 9
`define SBSC_LANES_WIDE 4
`define SBSC_LANES_NARROW 2
`define SBSC_ADDR_BITS 19
`define SBSC_LOW_BITS 2
`define SBSC_LOW_LSB 0
`define SBSC_COUNT_RESET 2'h0
`define SBSC_READ_STAGES_FLOW 2
`define SBSC_READ_STAGES_PIPE 3
`endif

//--- common/sbsc_pkg.sv
// Types shared by the burst SRAM control block
package sbsc_pkg;
    // One-hot access kinds
    typedef enum logic [3:0] {
        OP_DESELECT = 4'h1,
        OP_READ = 4'h2,
        OP_WRITE = 4'h4,
        OP_SLEEP = 4'h8
    } sbsc_op_type;

    // Synchronous control pins as sampled at the clock edge
    typedef struct packed {
        logic cpu_load_strobe_n;
        logic ctrl_load_strobe_n;
        logic burst_step_n;
        logic primary_select_n;
        logic positive_select;
        logic tertiary_select_n;
        logic all_lanes_write_n;
        logic byte_lane_gate_n;
    } sbsc_ctrl_type;

    // Static mode pins
    typedef struct packed {
        logic flow_through_select_n;
        logic sleep_request;
        logic linear_order_select_n;
    } sbsc_mode_type;

    // Burst counter state
    typedef struct packed {
        logic [1:0] base;
        logic [1:0] step_count;
    } sbsc_count_type;
endpackage : sbsc_pkg

//--- hdl/sbsc_burst_counter.sv
// Two-bit burst address counter, linear or interleaved
`include "sbsc_defs.svh"
module sbsc_burst_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [1:0] load_value,
    input wire logic step,
    input wire logic interleave,
    // Addresses
    output logic [1:0] cur_low,
    output logic [1:0] next_low
);
    sbsc_pkg::sbsc_count_type state_reg;
    sbsc_pkg::sbsc_count_type state_next;
    logic [1:0] next_count;

    // Count wraps modulo four, so the fifth address repeats the first
    assign next_count = state_reg.step_count + 2'h1;

    always_comb begin
        if (interleave) begin
            cur_low = state_reg.base ^ state_reg.step_count;
            next_low = state_reg.base ^ next_count;
        end else begin
            cur_low = state_reg.base + state_reg.step_count;
            next_low = state_reg.base + next_count;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (load) begin
            state_next.base = load_value;
            state_next.step_count = `SBSC_COUNT_RESET;
        end else if (step) begin
            state_next.step_count = next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= {`SBSC_COUNT_RESET, `SBSC_COUNT_RESET};
        end else begin
            state_reg <= state_next;
        end
    end
endmodule : sbsc_burst_counter

//--- testbench/sbsc_control_checker.sv
// Port assertions for the burst SRAM control block
module sbsc_control_checker #(
    parameter int LANES = 4,
    parameter int LANE_BITS = 9,
    parameter int ADDR_BITS = 19
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire logic [ADDR_BITS-1:0] addr,
    input wire sbsc_pkg::sbsc_ctrl_type ctrl,
    input wire logic [LANES-1:0] lane_write_n,
    input wire logic output_enable_n,
    input wire sbsc_pkg::sbsc_mode_type mode,
    // Outputs
    input wire logic [LANES-1:0] dq_oe_n,
    input wire logic mem_rd_en,
    input wire logic [ADDR_BITS-1:0] mem_rd_addr,
    input wire logic [LANES-1:0] mem_wr_lanes,
    input wire logic standby,
    input wire logic powered_down
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic chip, qual, rd_go, wr_go, desel, cont, awake, flow;
    logic [LANES-1:0] lanes;
    assign awake = ~mode.sleep_request;
    assign flow = ~mode.flow_through_select_n;
    assign chip = ctrl.positive_select & ~ctrl.tertiary_select_n;
    assign qual = ~ctrl.all_lanes_write_n | (~ctrl.byte_lane_gate_n & ~&lane_write_n);
    assign lanes = ctrl.all_lanes_write_n ? ~lane_write_n : '1;
    assign rd_go = awake & ~ctrl.primary_select_n & chip
        & (~ctrl.cpu_load_strobe_n | (~ctrl.ctrl_load_strobe_n & ~qual));
    assign wr_go = awake & ~ctrl.primary_select_n & chip & ctrl.cpu_load_strobe_n & ~ctrl.ctrl_load_strobe_n & qual;
    assign desel = awake & (ctrl.primary_select_n ? ~ctrl.ctrl_load_strobe_n
        : ~chip & ~(ctrl.cpu_load_strobe_n & ctrl.ctrl_load_strobe_n));
    // Continue or suspend: neither strobe loads an address
    assign cont = awake & ctrl.ctrl_load_strobe_n & (ctrl.cpu_load_strobe_n | ctrl.primary_select_n) & ~qual;

    rd_load_a: assert property (rd_go |=> mem_rd_en && mem_rd_addr == $past(addr))
        else $error("read begin missing at array port");
    wr_lanes_a: assert property (wr_go |-> ##2 mem_wr_lanes == $past(lanes, 2))
        else $error("wrong write lanes");
    desel_a: assert property (desel |=> powered_down && !mem_rd_en)
        else $error("deselect not taken");
    sleep_a: assert property (mode.sleep_request |=> standby && !mem_rd_en ##1 mem_wr_lanes == '0)
        else $error("sleep let an access through");
    oe_off_a: assert property (output_enable_n |-> &dq_oe_n)
        else $error("drivers on with output enable high");
    wr_hiz_a: assert property (wr_go && flow |-> ##2 &dq_oe_n)
        else $error("drivers on during write");
    rd_drive_a: assert property (rd_go && flow |-> ##2 (output_enable_n || dq_oe_n == '0))
        else $error("flow read not driven");
    pipe_rd_a: assert property (rd_go && !flow ##1 rd_go |-> ##2 (output_enable_n || dq_oe_n == '0))
        else $error("pipelined read not driven");
    scd_off_a: assert property (rd_go && !flow ##1 desel |-> ##2 &dq_oe_n)
        else $error("outputs not off after deselect");
    step_a: assert property (cont && !ctrl.burst_step_n && !mode.linear_order_select_n && mem_rd_en
        |=> mem_rd_addr == {$past(mem_rd_addr[ADDR_BITS-1:2]), $past(mem_rd_addr[1:0]) + 2'h1})
        else $error("linear step wrong");
    hold_a: assert property (cont && ctrl.burst_step_n && mem_rd_en |=> mem_rd_addr == $past(mem_rd_addr))
        else $error("suspend moved address");

    cover property (cont && !ctrl.burst_step_n && mem_rd_en);
    cover property (wr_go);
    cover property (rd_go && !flow ##1 desel);
endmodule : sbsc_control_checker

//--- testbench/sbsc_array_model.sv
// Storage array model behind the control block's array ports
module sbsc_array_model (
    // Clock
    input wire logic clk,
    // Read port
    input wire logic mem_rd_en,
    input wire logic [18:0] mem_rd_addr,
    output logic [35:0] mem_rdata,
    // Write port
    input wire logic [3:0] mem_wr_lanes,
    input wire logic [18:0] mem_wr_addr,
    input wire logic [35:0] mem_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] mem [16];
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {4{5'h00, 4'(i)}};
        end
    end
    // Unrequested reads give inverted data so stale use shows up
    assign mem_rdata = mem_rd_en ? mem[mem_rd_addr[3:0]] : ~mem[mem_rd_addr[3:0]];
    always @(posedge clk) begin
        for (int l = 0; l < 4; l++) begin
            if (mem_wr_lanes[l]) begin
                mem[mem_wr_addr[3:0]][l*9 +: 9] <= mem_wdata[l*9 +: 9];
            end
        end
    end
endmodule : sbsc_array_model

//--- testbench/tb.sv
// Self-checking bench for the burst SRAM control block
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DESEL = 8'hbb, RD_C = 8'hab, STEP = 8'h5b, SUSP = 8'heb;
    logic clk = 0, rst = 1, output_enable_n = 0, mem_rd_en, standby, powered_down;
    logic [18:0] addr = '0, mem_rd_addr, mem_wr_addr;
    logic [35:0] dq_in = '0, dq_out, mem_rdata, mem_wdata, w;
    logic [3:0] lane_write_n = '1, dq_oe_n, mem_wr_lanes;
    logic [1:0] exp;
    sbsc_pkg::sbsc_ctrl_type ctrl = DESEL;
    sbsc_pkg::sbsc_mode_type mode = 3'h0;
    int error_cnt = 0, checks = 0, cycles = 0;
    // Row: command, lane enables, read expected, write lanes expected, powered down
    logic [17:0] tbl [8] = '{{8'h68, 4'h0, 1'b1, 4'h0, 1'b0}, {8'hab, 4'h0, 1'b1, 4'h0, 1'b0},
        {8'haa, 4'hf, 1'b1, 4'h0, 1'b0}, {8'ha9, 4'h5, 1'b0, 4'hf, 1'b0}, {8'haa, 4'h5, 1'b0, 4'ha, 1'b0},
        {8'hbb, 4'h0, 1'b0, 4'h0, 1'b1}, {8'h63, 4'h0, 1'b0, 4'h0, 1'b1}, {8'haf, 4'h0, 1'b0, 4'h0, 1'b1}};

    sbsc_control #(.LANES(4), .LANE_BITS(9), .ADDR_BITS(19)) i_dut (.clk, .rst, .addr, .ctrl, .lane_write_n,
        .output_enable_n, .mode, .dq_in, .dq_out, .dq_oe_n, .mem_rd_en, .mem_rd_addr, .mem_rdata,
        .mem_wr_lanes, .mem_wr_addr, .mem_wdata, .standby, .powered_down);
    sbsc_array_model i_mem (.clk, .mem_rd_en, .mem_rd_addr, .mem_rdata, .mem_wr_lanes, .mem_wr_addr, .mem_wdata);

    always #20 clk = ~clk;

    function automatic logic [35:0] iw(input logic [3:0] a);
        return {4{5'h00, a}};
    endfunction : iw

    task automatic go(input logic [7:0] c, input logic [3:0] a);
        @(posedge clk);
        ctrl <= c;
        addr <= 19'(a);
    endtask : go

    task automatic report_and_stop;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Ceiling far above the roughly 70 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({powered_down, dq_oe_n, mem_rd_en}, 6'h3e)
        foreach (tbl[i]) begin
            @(posedge clk);
            ctrl <= tbl[i][17:10];
            lane_write_n <= tbl[i][9:6];
            @(posedge clk);
            ctrl <= DESEL;
            #1;
            `CHK({mem_rd_en, powered_down}, {tbl[i][5], tbl[i][0]})
            @(posedge clk);
            #1;
            `CHK(mem_wr_lanes, tbl[i][4:1])
        end
        // Burst in both orders; second pass is dummy reads with drivers held off
        for (int il = 0; il < 2; il++) begin
            @(posedge clk);
            // Deselect while the order pin moves, so no suspend sees a half-switched counter
            ctrl <= DESEL;
            mode.linear_order_select_n <= il[0];
            output_enable_n <= il[0];
            go(RD_C, 4'h1);
            for (int k = 0; k < 7; k++) begin
                @(posedge clk);
                ctrl <= (k < 5) ? STEP : SUSP;
                #1;
                exp = il ? 2'h1 ^ 2'(k < 6 ? k : 5) : 2'(1 + (k < 6 ? k : 5));
                `CHK(mem_rd_addr[1:0], exp)
                if (il) `CHK(dq_oe_n, 4'hf)
            end
        end
        // Two reads then deselect, flow then pipelined
        for (int fm = 0; fm < 2; fm++) begin
            @(posedge clk);
            ctrl <= DESEL;
            mode <= {fm[0], 2'b00};
            output_enable_n <= 1'b0;
            go(RD_C, 4'h5);
            go(RD_C, 4'h6);
            go(DESEL, 4'h0);
            for (int j = 0; j < 3; j++) begin
                #1;
                `CHK(dq_oe_n, ((fm ? j == 1 : j < 2) ? 4'h0 : 4'hf))
                if (fm ? j == 1 : j < 2) `CHK(dq_out, iw(4'(fm ? 5 : 5 + j)))
                @(posedge clk);
            end
        end
        // Lane b write, then a write blocked by sleep, then read back
        mode <= 3'h0;
        lane_write_n <= 4'b1101;
        go(8'haa, 4'h3);
        @(posedge clk);
        ctrl <= DESEL;
        dq_in <= 36'h1_2345_6789;
        @(posedge clk);
        #1;
        `CHK({mem_wr_lanes, dq_oe_n}, 8'h2f)
        go(8'ha9, 4'h3);
        mode.sleep_request <= 1'b1;
        dq_in <= '0;
        @(posedge clk);
        ctrl <= DESEL;
        mode.sleep_request <= 1'b0;
        #1;
        `CHK(standby, 1'b1)
        @(posedge clk);
        #1;
        `CHK(mem_wr_lanes, 4'h0)
        go(RD_C, 4'h3);
        repeat (2) @(posedge clk);
        #1;
        w = iw(4'h3);
        w[17:9] = 9'h0b3;
        `CHK(dq_out, w)
        report_and_stop();
    end
endmodule : tb

bind sbsc_control sbsc_control_checker #(.LANES(LANES), .LANE_BITS(LANE_BITS), .ADDR_BITS(ADDR_BITS)) i_chk (
    .clk, .rst, .addr, .ctrl, .lane_write_n, .output_enable_n, .mode, .dq_oe_n, .mem_rd_en, .mem_rd_addr,
    .mem_wr_lanes, .standby, .powered_down);
